// ---- logic/afb_frame_builder.sv ----
// Purpose: builds receive, remote reply and local reply frames for the host link
// Assumes: caller gives a header request, then streams exactly REQ_LEN value bytes, or none for a non-query command reply or a refused request
// Notes: one accepted request makes one frame; multi-frame replies are several requests
`timescale 1ns/1ps
module afb_frame_builder #(
    parameter int FIFO_DEPTH = afb_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    // frame request
    input wire logic REQ_VALID,
    output logic REQ_READY,
    output logic REQ_REJECT,
    input wire logic [1:0] REQ_KIND,
    input wire logic [7:0] REQ_FRAME_ID,
    input wire logic [31:0] REQ_IP,
    input wire logic [7:0] REQ_RSSI,
    input wire logic [15:0] REQ_CMD,
    input wire logic [7:0] REQ_STATUS,
    input wire logic REQ_QUERY,
    input wire logic [10:0] REQ_LEN,
    // payload or value bytes
    input wire logic PAY_VALID,
    output logic PAY_READY,
    input wire logic [7:0] PAY_DATA,
    // serial-side byte stream
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [7:0] TX_DATA,
    output logic TX_LAST
);
    afb_stream_if #(.W(8)) wr_s ();
    afb_stream_if #(.W(8)) rd_s ();

    afb_pkg::afb_state_t state;
    afb_pkg::afb_kind_t kind;
    logic [7:0] frame_id;
    logic [31:0] ip;
    logic [7:0] rssi;
    logic [15:0] cmd;
    logic [7:0] status;
    logic [10:0] rem;
    logic [15:0] flen;
    afb_pkg::afb_off_t pos;
    afb_pkg::afb_off_t data_off;
    afb_pkg::afb_off_t out_off;
    logic [7:0] sum;
    logic [7:0] hdr;
    logic out_free;
    logic emit;
    logic [7:0] emit_byte;
    logic req_take;
    logic too_long;
    logic [10:0] eff_len;
    afb_pkg::afb_off_t req_doff;

    assign wr_s.valid = PAY_VALID;
    assign wr_s.data = PAY_DATA;
    assign PAY_READY = wr_s.ready;

    afb_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .wr(wr_s),
        .rd(rd_s)
    );

    // byte of a 32-bit address, high byte first from base
    function automatic logic [7:0] ip_byte(input logic [31:0] a, input afb_pkg::afb_off_t o,
                                           input afb_pkg::afb_off_t base);
        logic [1:0] i;
        i = 2'(o - base);
        ip_byte = a[8'(31 - 8 * i) -: 8];
    endfunction

    // status outside the documented range reports general error
    function automatic logic [7:0] clamp_stat(input logic [7:0] s, input logic [7:0] mx);
        clamp_stat = (s > mx) ? afb_pkg::STAT_ERR : s;
    endfunction

    assign out_free = !TX_VALID || TX_READY;
    assign req_take = REQ_VALID && REQ_READY;
    assign too_long = (afb_pkg::afb_kind_t'(REQ_KIND) == afb_pkg::AFB_KIND_RX) &&
                      (REQ_LEN > afb_pkg::MAX_RX_DATA);

    always_comb begin
        case (afb_pkg::afb_kind_t'(REQ_KIND))
            afb_pkg::AFB_KIND_RX: req_doff = afb_pkg::OFF_RX_DATA;
            afb_pkg::AFB_KIND_REM: req_doff = afb_pkg::OFF_REM_DATA;
            default: req_doff = afb_pkg::OFF_LOC_DATA;
        endcase
        // value bytes only for queries on command replies
        if (afb_pkg::afb_kind_t'(REQ_KIND) != afb_pkg::AFB_KIND_RX && !REQ_QUERY) begin
            eff_len = '0;
        end else begin
            eff_len = REQ_LEN;
        end
    end

    // header byte at the current offset
    always_comb begin
        hdr = 8'h00;
        if (pos == afb_pkg::OFF_DELIM) begin
            hdr = afb_pkg::DELIM;
        end else if (pos == afb_pkg::OFF_LEN_MSB) begin
            hdr = flen[15:8];
        end else if (pos == afb_pkg::OFF_LEN_LSB) begin
            hdr = flen[7:0];
        end else if (pos == afb_pkg::OFF_TYPE) begin
            case (kind)
                afb_pkg::AFB_KIND_RX: hdr = afb_pkg::TYPE_RX;
                afb_pkg::AFB_KIND_REM: hdr = afb_pkg::TYPE_REM;
                default: hdr = afb_pkg::TYPE_LOC;
            endcase
        end else begin
            case (kind)
                afb_pkg::AFB_KIND_RX: begin
                    if (pos >= afb_pkg::OFF_RX_IP && pos < afb_pkg::OFF_RX_RSSI) begin
                        hdr = ip_byte(ip, pos, afb_pkg::OFF_RX_IP);
                    end else if (pos == afb_pkg::OFF_RX_RSSI) begin
                        hdr = rssi;
                    end else if (pos == afb_pkg::OFF_RX_OPT) begin
                        hdr = afb_pkg::OPT_NONE;
                    end
                end
                afb_pkg::AFB_KIND_REM: begin
                    if (pos == afb_pkg::OFF_ID) begin
                        hdr = frame_id;
                    end else if (pos >= afb_pkg::OFF_REM_IP && pos < afb_pkg::OFF_REM_CMD) begin
                        hdr = ip_byte(ip, pos, afb_pkg::OFF_REM_IP);
                    end else if (pos == afb_pkg::OFF_REM_CMD) begin
                        hdr = cmd[15:8];
                    end else if (pos == afb_pkg::OFF_REM_CMD + 12'h001) begin
                        hdr = cmd[7:0];
                    end else if (pos == afb_pkg::OFF_REM_STAT) begin
                        hdr = status;
                    end
                end
                default: begin
                    if (pos == afb_pkg::OFF_ID) begin
                        hdr = frame_id;
                    end else if (pos == afb_pkg::OFF_LOC_CMD) begin
                        hdr = cmd[15:8];
                    end else if (pos == afb_pkg::OFF_LOC_CMD + 12'h001) begin
                        hdr = cmd[7:0];
                    end else if (pos == afb_pkg::OFF_LOC_STAT) begin
                        hdr = status;
                    end
                end
            endcase
        end
    end

    always_comb begin
        emit = 1'b0;
        emit_byte = hdr;
        rd_s.ready = 1'b0;
        case (state)
            afb_pkg::AFB_ST_HEAD: emit = out_free;
            afb_pkg::AFB_ST_BODY: begin
                rd_s.ready = out_free;
                emit = out_free && rd_s.valid;
                emit_byte = rd_s.data;
            end
            afb_pkg::AFB_ST_SUM: begin
                emit = out_free;
                emit_byte = afb_pkg::CSUM_BASE - sum;
            end
            default: emit = 1'b0;
        endcase
    end

    // request capture
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            kind <= afb_pkg::AFB_KIND_RX;
            frame_id <= 8'h00;
            ip <= 32'h0000_0000;
            rssi <= 8'h00;
            cmd <= 16'h0000;
            status <= 8'h00;
            data_off <= afb_pkg::OFF_RX_DATA;
            flen <= 16'h0000;
        end else if (req_take && !too_long) begin
            kind <= afb_pkg::afb_kind_t'(REQ_KIND);
            frame_id <= REQ_FRAME_ID;
            ip <= REQ_IP;
            rssi <= REQ_RSSI;
            cmd <= REQ_CMD;
            status <= clamp_stat(REQ_STATUS, (afb_pkg::afb_kind_t'(REQ_KIND) == afb_pkg::AFB_KIND_REM) ?
                                 afb_pkg::REM_STAT_MAX : afb_pkg::LOC_STAT_MAX);
            data_off <= req_doff;
            flen <= 16'(req_doff - afb_pkg::OFF_TYPE) + {5'h00, eff_len};
        end
    end

    // sequencing
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= afb_pkg::AFB_ST_IDLE;
            REQ_READY <= 1'b0;
            REQ_REJECT <= 1'b0;
            pos <= afb_pkg::OFF_DELIM;
            rem <= '0;
        end else begin
            REQ_REJECT <= req_take && too_long;
            case (state)
                afb_pkg::AFB_ST_IDLE: begin
                    REQ_READY <= 1'b1;
                    if (req_take && !too_long) begin
                        REQ_READY <= 1'b0;
                        state <= afb_pkg::AFB_ST_HEAD;
                        pos <= afb_pkg::OFF_DELIM;
                        rem <= eff_len;
                    end
                end
                afb_pkg::AFB_ST_HEAD: begin
                    if (emit) begin
                        pos <= pos + 12'h001;
                        if (pos == data_off - 12'h001) begin
                            state <= (rem == '0) ? afb_pkg::AFB_ST_SUM : afb_pkg::AFB_ST_BODY;
                        end
                    end
                end
                afb_pkg::AFB_ST_BODY: begin
                    if (emit) begin
                        pos <= pos + 12'h001;
                        rem <= rem - 11'h001;
                        if (rem == 11'h001) begin
                            state <= afb_pkg::AFB_ST_SUM;
                        end
                    end
                end
                afb_pkg::AFB_ST_SUM: begin
                    if (emit) begin
                        state <= afb_pkg::AFB_ST_IDLE;
                        REQ_READY <= 1'b1;
                    end
                end
                default: state <= afb_pkg::AFB_ST_IDLE;
            endcase
        end
    end

    // checksum over type byte onward
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sum <= 8'h00;
        end else if (emit && state == afb_pkg::AFB_ST_HEAD && pos == afb_pkg::OFF_DELIM) begin
            // clear only once the previous checksum byte has left the output
            // register, so a stalled checksum byte still matches its sum
            sum <= 8'h00;
        end else if (emit && state != afb_pkg::AFB_ST_SUM && pos >= afb_pkg::OFF_TYPE) begin
            sum <= sum + emit_byte;
        end
    end

    // output register
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            TX_VALID <= 1'b0;
            TX_DATA <= 8'h00;
            TX_LAST <= 1'b0;
            out_off <= afb_pkg::OFF_DELIM;
        end else if (emit) begin
            TX_VALID <= 1'b1;
            TX_DATA <= emit_byte;
            TX_LAST <= state == afb_pkg::AFB_ST_SUM;
            out_off <= pos;
        end else if (TX_READY) begin
            TX_VALID <= 1'b0;
            TX_LAST <= 1'b0;
        end
    end

    // frame content and hold checks at the output register, oversize refusal check and coverage
    AST_DELIM: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && !TX_LAST && out_off == afb_pkg::OFF_DELIM |-> TX_DATA == afb_pkg::DELIM)
        else $error("delimiter byte wrong");
    AST_RX_TYPE: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && !TX_LAST && out_off == afb_pkg::OFF_TYPE && kind == afb_pkg::AFB_KIND_RX
        |-> TX_DATA == afb_pkg::TYPE_RX)
        else $error("receive type byte wrong");
    AST_RX_ADDR_HIGH: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && !TX_LAST && kind == afb_pkg::AFB_KIND_RX && out_off >= afb_pkg::OFF_ID &&
        out_off < afb_pkg::OFF_RX_IP |-> TX_DATA == 8'h00)
        else $error("upper address byte not zero");
    AST_RX_RSSI: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && !TX_LAST && kind == afb_pkg::AFB_KIND_RX && out_off == afb_pkg::OFF_RX_RSSI
        |-> TX_DATA == rssi)
        else $error("margin byte wrong");
    AST_RX_OPT: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && !TX_LAST && kind == afb_pkg::AFB_KIND_RX && out_off == afb_pkg::OFF_RX_OPT
        |-> TX_DATA == afb_pkg::OPT_NONE)
        else $error("options byte not zero");
    AST_RX_LIMIT: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        REQ_VALID && REQ_READY && REQ_KIND == 2'h0 && REQ_LEN > afb_pkg::MAX_RX_DATA
        |=> REQ_REJECT && state == afb_pkg::AFB_ST_IDLE)
        else $error("oversize payload not refused");
    AST_REM_TYPE: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && !TX_LAST && out_off == afb_pkg::OFF_TYPE && kind == afb_pkg::AFB_KIND_REM
        |-> TX_DATA == afb_pkg::TYPE_REM)
        else $error("remote type byte wrong");
    AST_REM_CMD: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && !TX_LAST && kind == afb_pkg::AFB_KIND_REM && out_off == afb_pkg::OFF_REM_CMD
        |-> TX_DATA == cmd[15:8])
        else $error("remote command byte wrong");
    AST_REM_STAT: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && !TX_LAST && kind == afb_pkg::AFB_KIND_REM && out_off == afb_pkg::OFF_REM_STAT
        |-> TX_DATA <= afb_pkg::REM_STAT_MAX)
        else $error("remote result out of range");
    AST_LOC_TYPE: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && !TX_LAST && out_off == afb_pkg::OFF_TYPE && kind == afb_pkg::AFB_KIND_LOC
        |-> TX_DATA == afb_pkg::TYPE_LOC)
        else $error("local type byte wrong");
    AST_CSUM: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && TX_LAST |-> TX_DATA == 8'(afb_pkg::CSUM_BASE - sum))
        else $error("checksum wrong");
    AST_HOLD: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
        else $error("byte changed while stalled");
    COV_RX: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && TX_LAST && kind == afb_pkg::AFB_KIND_RX);
    COV_REM_QUERY: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && TX_LAST && kind == afb_pkg::AFB_KIND_REM && out_off > afb_pkg::OFF_REM_DATA);
    COV_LOC_SET: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
        TX_VALID && TX_LAST && kind == afb_pkg::AFB_KIND_LOC && out_off == afb_pkg::OFF_LOC_DATA);
    COV_REJECT: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) REQ_REJECT);
endmodule

// ---- logic/afb_pkg.sv ----
// Purpose: shared constants and types of the API response frame builder
// Assumes: byte offsets count from the start delimiter at offset 0
// Notes: offsets are 12 bits wide so a full frame fits the counter
package afb_pkg;
    typedef logic [11:0] afb_off_t;
    typedef enum logic [1:0] {
        AFB_KIND_RX = 2'h0,
        AFB_KIND_REM = 2'h1,
        AFB_KIND_LOC = 2'h2
    } afb_kind_t;
    typedef enum logic [3:0] {
        AFB_ST_IDLE = 4'h1,
        AFB_ST_HEAD = 4'h2,
        AFB_ST_BODY = 4'h4,
        AFB_ST_SUM = 4'h8
    } afb_state_t;
    localparam logic [7:0] DELIM = 8'h7e;
    localparam logic [7:0] TYPE_RX = 8'h80;
    localparam logic [7:0] TYPE_REM = 8'h87;
    localparam logic [7:0] TYPE_LOC = 8'h88;
    localparam logic [7:0] OPT_NONE = 8'h00;
    localparam logic [7:0] CSUM_BASE = 8'hff;
    localparam logic [7:0] STAT_ERR = 8'h01;
    localparam logic [7:0] REM_STAT_MAX = 8'h04;
    localparam logic [7:0] LOC_STAT_MAX = 8'h03;
    localparam afb_off_t OFF_DELIM = 12'h000;
    localparam afb_off_t OFF_LEN_MSB = 12'h001;
    localparam afb_off_t OFF_LEN_LSB = 12'h002;
    localparam afb_off_t OFF_TYPE = 12'h003;
    localparam afb_off_t OFF_ID = 12'h004;
    localparam afb_off_t OFF_RX_IP = 12'h008;
    localparam afb_off_t OFF_RX_RSSI = 12'h00c;
    localparam afb_off_t OFF_RX_OPT = 12'h00d;
    localparam afb_off_t OFF_RX_DATA = 12'h00e;
    localparam afb_off_t OFF_REM_ADDR = 12'h005;
    localparam afb_off_t OFF_REM_IP = 12'h009;
    localparam afb_off_t OFF_REM_CMD = 12'h00d;
    localparam afb_off_t OFF_REM_STAT = 12'h00f;
    localparam afb_off_t OFF_REM_DATA = 12'h010;
    localparam afb_off_t OFF_LOC_CMD = 12'h005;
    localparam afb_off_t OFF_LOC_STAT = 12'h007;
    localparam afb_off_t OFF_LOC_DATA = 12'h008;
    localparam afb_off_t IP_BYTES = 12'h004;
    localparam logic [10:0] MAX_RX_DATA = 11'h570;
    localparam int FIFO_DEPTH = 8;
endpackage

// ---- logic/afb_stream_if.sv ----
// Purpose: byte stream carrier between the framer and its payload fifo
// Assumes: valid/ready handshake, a byte moves when both are high
// Notes: none
`timescale 1ns/1ps
interface afb_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- logic/afb_fifo.sv ----
// Purpose: payload fifo with registered read data
// Assumes: one clock, asynchronous active-low reset
// Notes: ready on the write side is a flop, so it looks one cycle ahead
`timescale 1ns/1ps
module afb_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // streams
    afb_stream_if.snk wr,
    afb_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [AW:0] next_cnt;
    logic in_rdy;
    logic out_vld;
    logic [W-1:0] out_dat;
    logic push;
    logic pop;

    assign wr.ready = in_rdy;
    assign rd.valid = out_vld;
    assign rd.data = out_dat;
    assign push = wr.valid && in_rdy;
    // refill the output register from storage
    assign pop = (cnt != '0) && (!out_vld || rd.ready);

    always_comb begin
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop && !push) begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
            in_rdy <= 1'b0;
            wp <= '0;
            rp <= '0;
        end else begin
            cnt <= next_cnt;
            in_rdy <= next_cnt < (AW+1)'(DEPTH);
            if (push) begin
                wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_vld <= 1'b0;
            out_dat <= '0;
        end else if (pop) begin
            out_vld <= 1'b1;
            out_dat <= mem[rp];
        end else if (rd.ready) begin
            out_vld <= 1'b0;
        end
    end
endmodule

// ---- verif/afb_host_model.sv ----
// Purpose: host side of the serial link, takes and parses frames
// Assumes: byte moves on tx_valid and tx_ready at a rising edge
// Notes: slow makes the host stall at random
`timescale 1ns/1ps
module afb_host_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // byte stream from the framer
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready = 1'b0,
    // control and results
    input wire logic slow,
    output logic got,
    output logic [7:0] got_data,
    output logic bad
);
    int pos;
    int len;
    logic [7:0] sum;
    always @(negedge clk) begin
        tx_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
    end
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos <= 0;
            got <= 1'b0;
            bad <= 1'b0;
        end else begin
            got <= tx_valid && tx_ready;
            got_data <= tx_data;
            if (tx_valid && tx_ready) begin
                if (pos == 0 && tx_data != 8'h7e) bad <= 1'b1;
                if (pos == 1) len <= int'(tx_data) << 8;
                if (pos == 2) len <= len | int'(tx_data);
                sum <= (pos < 3) ? 8'h00 : sum + tx_data;
                pos <= pos + 1;
                if (tx_last) begin
                    pos <= 0;
                    if (pos != len + 3 || sum + tx_data != 8'hff) bad <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- verif/api_response_frame_builder_tb_top.sv ----
// Purpose: self-checking bench of the frame builder
// Assumes: inputs change at the falling edge
// Notes: expected bytes queue up per frame, the watcher pops them
`timescale 1ns/1ps
module api_response_frame_builder_tb_top;
    logic CORE_CLK = 1'b0, ARST_N = 1'b0, REQ_VALID = 1'b0, REQ_QUERY = 1'b0, PAY_VALID = 1'b0, slow = 1'b0;
    logic REQ_READY, REQ_REJECT, PAY_READY, TX_VALID, TX_READY, TX_LAST, got, bad;
    logic [1:0] REQ_KIND = 2'h0;
    logic [7:0] REQ_FRAME_ID = 8'h00, REQ_RSSI = 8'h00, REQ_STATUS = 8'h00, PAY_DATA = 8'h00, TX_DATA, got_data;
    logic [31:0] REQ_IP = 32'h0;
    logic [15:0] REQ_CMD = 16'h0;
    logic [10:0] REQ_LEN = 11'h0;
    logic [7:0] exp_q[$];
    int num_errors = 0, n_tests = 0, cyc = 0;
    int rx_lens[4] = '{0, 1, 20, 1392};
    afb_frame_builder afb_frame_builder_inst (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID),
        .REQ_READY(REQ_READY), .REQ_REJECT(REQ_REJECT), .REQ_KIND(REQ_KIND), .REQ_FRAME_ID(REQ_FRAME_ID),
        .REQ_IP(REQ_IP), .REQ_RSSI(REQ_RSSI), .REQ_CMD(REQ_CMD), .REQ_STATUS(REQ_STATUS), .REQ_QUERY(REQ_QUERY),
        .REQ_LEN(REQ_LEN), .PAY_VALID(PAY_VALID), .PAY_READY(PAY_READY), .PAY_DATA(PAY_DATA),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST));
    afb_host_model afb_host_model_inst (.clk(CORE_CLK), .arst_n(ARST_N), .tx_valid(TX_VALID), .tx_data(TX_DATA),
        .tx_last(TX_LAST), .tx_ready(TX_READY), .slow(slow), .got(got), .got_data(got_data), .bad(bad));
    initial begin
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end
    task check(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wrap_up;
        if (num_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watcher: each byte taken by the host is matched against the oldest note
    always @(negedge CORE_CLK) begin
        if (got === 1'b1 && exp_q.size() != 0) check(got_data, exp_q.pop_front());
        else if (got === 1'b1) begin
            n_tests++;
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got_data, 8'h00);
        end
    end
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 50000) begin
            num_errors++;
            wrap_up();
        end
    end
    // one request with its value bytes, expected frame noted first
    task automatic run(input logic [1:0] k, input logic [15:0] cmd, input logic [7:0] st, input logic q,
                       input int n);
        logic [7:0] b[$];
        logic [7:0] p[$];
        logic [7:0] s;
        logic [31:0] ip;
        logic [7:0] id;
        logic [7:0] rs;
        logic rj;
        logic rr;
        ip = $urandom;
        id = $urandom;
        rs = $urandom;
        rj = (k == 2'h0 && n > 1392);
        if (!rj && (k == 2'h0 || q)) for (int i = 0; i < n; i++) p.push_back(8'($urandom));
        if (k == 2'h0) b = {8'h80, 8'h00, 8'h00, 8'h00, 8'h00, ip[31:24], ip[23:16], ip[15:8], ip[7:0], rs, 8'h00};
        else if (k == 2'h1) b = {8'h87, id, 8'h00, 8'h00, 8'h00, 8'h00, ip[31:24], ip[23:16], ip[15:8], ip[7:0],
                                 cmd[15:8], cmd[7:0], (st > 8'h04) ? 8'h01 : st};
        else b = {8'h88, id, cmd[15:8], cmd[7:0], (st > 8'h03) ? 8'h01 : st};
        b = {b, p};
        s = 8'hff;
        foreach (b[i]) s -= b[i];
        if (!rj) exp_q = {exp_q, 8'h7e, 8'(b.size() >> 8), 8'(b.size()), b, s};
        @(negedge CORE_CLK);
        fork
            begin
                {REQ_KIND, REQ_CMD, REQ_STATUS, REQ_QUERY, REQ_LEN} = {k, cmd, st, q, 11'(n)};
                {REQ_IP, REQ_FRAME_ID, REQ_RSSI, REQ_VALID} = {ip, id, rs, 1'b1};
                while (REQ_READY !== 1'b1) @(negedge CORE_CLK);
                @(negedge CORE_CLK);
                REQ_VALID = 1'b0;
                rr = REQ_REJECT;
                @(negedge CORE_CLK);
                check(8'(rr | REQ_REJECT), 8'(rj));
            end
            begin
                foreach (p[i]) begin
                    PAY_DATA = p[i];
                    PAY_VALID = 1'b1;
                    while (PAY_READY !== 1'b1) @(negedge CORE_CLK);
                    @(negedge CORE_CLK);
                end
                PAY_VALID = 1'b0;
            end
        join
    endtask
    initial begin
        void'($urandom(32'h2c06c441));
        repeat (5) @(negedge CORE_CLK);
        ARST_N = 1'b1;
        repeat (2) @(negedge CORE_CLK);
        run(2'h2, 16'h4244, 8'h00, 1'b0, 5);
        for (int st = 0; st < 5; st++) run(2'h2, 16'h4153, 8'(st), 1'b1, st);
        run(2'h3, 16'h4153, 8'h02, 1'b1, 2);
        for (int st = 0; st < 6; st++) run(2'h1, 16'($urandom), 8'(st), st[0], 3);
        slow = 1'b1;
        foreach (rx_lens[i]) run(2'h0, 16'h0, 8'h00, 1'b0, rx_lens[i]);
        run(2'h0, 16'h0, 8'h00, 1'b0, 1393);
        run(2'h1, 16'h4244, 8'h07, 1'b1, 12);
        for (int i = 0; i < 4000 && exp_q.size() != 0; i++) @(negedge CORE_CLK);
        check(8'(exp_q.size()), 8'h00);
        check(8'(bad), 8'h00);
        wrap_up();
    end
endmodule
